// file: verilog/sts_defs.svh
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH

// register offsets (byte addresses on the 8-bit register port)
`define STS_TX_CTRL_ADDR    8'h50
`define STS_RX_CTRL_ADDR    8'h51
`define STS_TXI_SIG_HI_ADDR 8'h52
`define STS_TXI_SIG_LO_ADDR 8'h53
`define STS_TXQ_SIG_HI_ADDR 8'h54
`define STS_TXQ_SIG_LO_ADDR 8'h55
`define STS_RX_STATUS_ADDR  8'h56

// control register field positions
`define STS_BIT_ENABLE      0
`define STS_BIT_START       1
`define STS_BIT_FOREVER     2
`define STS_BIT_SOURCE      3
`define STS_BIT_PATTERN     4
`define STS_CTRL_USED_MASK  8'h1f

// reset values
`define STS_CTRL_RESET      8'h00
`define STS_SIG_RESET       16'h0000
`define STS_LFSR_SEED       12'hfff

// checkerboard words
`define STS_CHECKER_A       12'ha5a
`define STS_CHECKER_B       12'h5a5

// run length in words
`define STS_RUN_WORDS       10'h200
`define STS_RUN_LAST        10'h1ff

`endif

// file: verilog/sts_pkg.sv
package sts_pkg;

  typedef struct packed {
    logic [11:0] i_word;
    logic [11:0] q_word;
  } sts_pair_type;

  typedef struct packed {
    logic pattern_type;
    logic pattern_source;
    logic run_forever;
    logic start;
    logic selftest_on;
  } sts_ctrl_type;

  typedef enum logic [1:0] {
    STS_IDLE,
    STS_RUN,
    STS_DONE
  } sts_state_type;

endpackage

// file: verilog/sts_pattern_gen.sv
`timescale 1ns/10ps
`include "sts_defs.svh"

// one pattern generator per path: lfsr or checkerboard, i and q words
module sts_pattern_gen
  import sts_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         restart,
  input  wire logic         advance,
  input  wire logic         pattern_type,
  output sts_pair_type      word
);

  typedef struct packed {
    logic [11:0] lfsr;
    logic        phase;
  } sts_gen_state_type;

  sts_gen_state_type state_reg;
  sts_gen_state_type state_next;

  // 12-bit maximal lfsr, taps 12,6,4,1
  function automatic logic [11:0] sts_lfsr_step(input logic [11:0] v);
    sts_lfsr_step = {v[10:0], v[11] ^ v[5] ^ v[3] ^ v[0]};
  endfunction

  always_comb begin
    state_next = state_reg;
    if (restart) begin
      state_next.lfsr  = `STS_LFSR_SEED;
      state_next.phase = 1'b0;
    end else if (advance) begin
      state_next.lfsr  = sts_lfsr_step(state_reg.lfsr);
      state_next.phase = ~state_reg.phase;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{lfsr: `STS_LFSR_SEED, phase: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // in lfsr mode the q side takes the inverted lfsr so i and q differ
  always_comb begin
    if (pattern_type) begin
      word.i_word = state_reg.phase ? `STS_CHECKER_B : `STS_CHECKER_A; // [R1]
      word.q_word = state_reg.phase ? `STS_CHECKER_B : `STS_CHECKER_A; // [R1]
    end else begin
      word.i_word = state_reg.lfsr; // [R1]
      word.q_word = ~state_reg.lfsr;
    end
  end

endmodule

// file: verilog/sts_skid_buffer.sv
`timescale 1ns/10ps
`include "sts_defs.svh"

// two-entry buffer; in_ready depends only on registered fill
module sts_skid_buffer
  import sts_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  sts_pair_type      in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output sts_pair_type      out_data
);

  typedef struct packed {
    sts_pair_type [1:0] mem;
    logic               rd_ptr;
    logic               wr_ptr;
    logic [1:0]         count;
  } sts_buf_state_type;

  sts_buf_state_type state_reg;
  sts_buf_state_type state_next;

  logic push;
  logic pop;

  always_comb begin
    in_ready  = (state_reg.count != 2'h2);
    out_valid = (state_reg.count != 2'h0);
    out_data  = state_reg.mem[state_reg.rd_ptr];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    state_next = state_reg;
    if (flush) begin
      state_next.rd_ptr = 1'b0;
      state_next.wr_ptr = 1'b0;
      state_next.count  = 2'h0;
    end else begin
      if (push) begin
        state_next.mem[state_reg.wr_ptr] = in_data;
        state_next.wr_ptr = ~state_reg.wr_ptr;
      end
      if (pop) begin
        state_next.rd_ptr = ~state_reg.rd_ptr;
      end
      case ({push, pop})
        2'b10:   state_next.count = state_reg.count + 2'h1;
        2'b01:   state_next.count = state_reg.count - 2'h1;
        default: state_next.count = state_reg.count;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// file: verilog/sts_selftest.sv
//==========================================================
// Function
// R1: pattern bit picks lfsr or a5a/5a5 checkerboard
// R2: tx source bit picks generator or tx pins
// R3: rx source bit picks generator or rx pins
// R4: run bit: 512 words, or endless
// R5: engine idles at start 0, runs at 1
// R6: enable bit 0 gates engine on or off
// R7: tx i signature at 0x52 high, 0x53 low
// R8: tx q signature at 0x54 high, 0x55 low
// R9: control bits 0..4 used, 7:5 unused
// R10: signatures read-only, accumulate, hold after run
// R11: far side drives pins every cycle when external; code takes a pin change only once sync stages 2 and 3 agree
`timescale 1ns/10ps
`include "sts_defs.svh"

module sts_selftest
  import sts_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic [7:0]        reg_rdata,
  input  sts_pair_type      tx_pins,
  input  sts_pair_type      rx_pins,
  output logic              rx_test_valid,
  input  wire logic         rx_test_ready,
  output sts_pair_type      rx_test_word,
  output logic              tx_running,
  output logic              rx_running
);

  //==========================================================
  // state
  typedef struct packed {
    logic [7:0]    tx_ctrl;
    logic [7:0]    rx_ctrl;
    sts_state_type tx_state;
    sts_state_type rx_state;
    logic [9:0]    tx_count;
    logic [9:0]    rx_count;
    logic [15:0]   tx_i_signature;
    logic [15:0]   tx_q_signature;
    logic [15:0]   rx_signature;
    logic [7:0]    rdata;
    logic          rx_out_valid;
    sts_pair_type  rx_out_word;
    logic          tx_running;
    logic          rx_running;
  } sts_top_state_type;

  sts_top_state_type state_reg;
  sts_top_state_type state_next;

  //==========================================================
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  sts_pair_type tx_sync1_reg;
  sts_pair_type tx_sync2_reg;
  sts_pair_type tx_sync3_reg;
  sts_pair_type tx_pins_reg;
  sts_pair_type rx_sync1_reg;
  sts_pair_type rx_sync2_reg;
  sts_pair_type rx_sync3_reg;
  sts_pair_type rx_pins_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_sync1_reg <= '0;
      tx_sync2_reg <= '0;
      tx_sync3_reg <= '0;
      tx_pins_reg  <= '0;
      rx_sync1_reg <= '0;
      rx_sync2_reg <= '0;
      rx_sync3_reg <= '0;
      rx_pins_reg  <= '0;
    end else begin
      tx_sync1_reg <= tx_pins;
      tx_sync2_reg <= tx_sync1_reg;
      tx_sync3_reg <= tx_sync2_reg;
      rx_sync1_reg <= rx_pins;
      rx_sync2_reg <= rx_sync1_reg;
      rx_sync3_reg <= rx_sync2_reg;
      if (tx_sync2_reg == tx_sync3_reg) begin
        tx_pins_reg <= tx_sync3_reg;
      end
      if (rx_sync2_reg == rx_sync3_reg) begin
        rx_pins_reg <= rx_sync3_reg;
      end
    end
  end

  //==========================================================
  // helpers
  sts_ctrl_type tx_c;
  sts_ctrl_type rx_c;

  function automatic sts_ctrl_type sts_decode(input logic [7:0] r);
    sts_decode.selftest_on    = r[`STS_BIT_ENABLE];  // [R6] [R9]
    sts_decode.start          = r[`STS_BIT_START];   // [R9]
    sts_decode.run_forever    = r[`STS_BIT_FOREVER]; // [R9]
    sts_decode.pattern_source = r[`STS_BIT_SOURCE];  // [R9]
    sts_decode.pattern_type   = r[`STS_BIT_PATTERN]; // [R9]
  endfunction

  // crc-16 style signature step over a 12-bit word
  function automatic logic [15:0] sts_sig_step(input logic [15:0] s,
                                               input logic [11:0] w);
    logic [15:0] x;
    x = {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
    sts_sig_step = x ^ {4'h0, w};
  endfunction

  // an engine leaves idle only with both enable and start set
  function automatic logic sts_armed(input sts_ctrl_type c);
    sts_armed = c.selftest_on && c.start; // [R5] [R6]
  endfunction

  // a finite run ends on its last word; an endless one never does
  function automatic logic sts_at_end(input sts_ctrl_type c,
                                      input logic [9:0]   count);
    sts_at_end = !c.run_forever && (count == `STS_RUN_LAST); // [R4]
  endfunction

  assign tx_c = sts_decode(state_reg.tx_ctrl);
  assign rx_c = sts_decode(state_reg.rx_ctrl);

  //==========================================================
  // pattern generators
  logic         tx_go;
  logic         rx_go;
  logic         tx_restart;
  logic         rx_restart;
  logic         rx_push_ok;
  sts_pair_type tx_gen_word;
  sts_pair_type rx_gen_word;

  assign tx_restart = (state_reg.tx_state != STS_RUN);
  assign rx_restart = (state_reg.rx_state != STS_RUN);

  sts_pattern_gen u_tx_gen (
    .clk          (clk),
    .rstn         (rstn),
    .restart      (tx_restart),
    .advance      (tx_go),
    .pattern_type (tx_c.pattern_type),
    .word         (tx_gen_word)
  );

  sts_pattern_gen u_rx_gen (
    .clk          (clk),
    .rstn         (rstn),
    .restart      (rx_restart),
    .advance      (rx_go),
    .pattern_type (rx_c.pattern_type),
    .word         (rx_gen_word)
  );

  //==========================================================
  // receive word buffer: a stall by the consumer pauses the rx run
  sts_pair_type rx_word_in;
  sts_pair_type rx_buf_word;
  logic         rx_buf_valid;
  logic         rx_out_take;

  assign rx_word_in  = rx_c.pattern_source ? rx_pins_reg : rx_gen_word; // [R3] [R11]
  assign rx_go       = (state_reg.rx_state == STS_RUN) && rx_push_ok;
  assign rx_out_take = !state_reg.rx_out_valid || rx_test_ready;

  sts_skid_buffer u_rx_buf (
    .clk       (clk),
    .rstn      (rstn),
    .flush     (rx_restart && (state_reg.rx_state == STS_IDLE)),
    .in_valid  (rx_go),
    .in_ready  (rx_push_ok),
    .in_data   (rx_word_in),
    .out_valid (rx_buf_valid),
    .out_ready (rx_out_take),
    .out_data  (rx_buf_word)
  );

  //==========================================================
  // next state
  sts_pair_type tx_word;

  assign tx_word = tx_c.pattern_source ? tx_pins_reg : tx_gen_word; // [R2] [R11]
  assign tx_go   = (state_reg.tx_state == STS_RUN);

  always_comb begin
    state_next = state_reg;

    // register writes; signature addresses are read-only
    if (reg_write) begin
      case (reg_addr)
        `STS_TX_CTRL_ADDR: state_next.tx_ctrl = reg_wdata & `STS_CTRL_USED_MASK; // [R9]
        `STS_RX_CTRL_ADDR: state_next.rx_ctrl = reg_wdata & `STS_CTRL_USED_MASK; // [R9]
        default:           state_next.tx_ctrl = state_reg.tx_ctrl; // [R10]
      endcase
    end

    // register reads, data in the following cycle
    if (reg_read) begin
      case (reg_addr)
        `STS_TX_CTRL_ADDR:    state_next.rdata = state_reg.tx_ctrl;
        `STS_RX_CTRL_ADDR:    state_next.rdata = state_reg.rx_ctrl;
        `STS_TXI_SIG_HI_ADDR: state_next.rdata = state_reg.tx_i_signature[15:8]; // [R7]
        `STS_TXI_SIG_LO_ADDR: state_next.rdata = state_reg.tx_i_signature[7:0];  // [R7]
        `STS_TXQ_SIG_HI_ADDR: state_next.rdata = state_reg.tx_q_signature[15:8]; // [R8]
        `STS_TXQ_SIG_LO_ADDR: state_next.rdata = state_reg.tx_q_signature[7:0];  // [R8]
        `STS_RX_STATUS_ADDR:  state_next.rdata = {6'h00, state_reg.rx_running,
                                                  state_reg.tx_running};
        default:              state_next.rdata = 8'h00;
      endcase
    end else begin
      state_next.rdata = 8'h00;
    end

    // tx engine
    case (state_reg.tx_state)
      STS_IDLE: begin
        if (sts_armed(tx_c)) begin // [R5] [R6]
          state_next.tx_state       = STS_RUN;
          state_next.tx_count       = 10'h000;
          state_next.tx_i_signature = `STS_SIG_RESET; // [R10]
          state_next.tx_q_signature = `STS_SIG_RESET; // [R10]
        end
      end
      // done holds the signature until start or enable is dropped
      STS_DONE: begin
        if (!sts_armed(tx_c)) begin // [R10]
          state_next.tx_state = STS_IDLE;
        end
      end
      STS_RUN: begin
        state_next.tx_i_signature = sts_sig_step(state_reg.tx_i_signature,
                                                 tx_word.i_word); // [R10]
        state_next.tx_q_signature = sts_sig_step(state_reg.tx_q_signature,
                                                 tx_word.q_word); // [R10]
        state_next.tx_count = state_reg.tx_count + 10'h001;
        if (!sts_armed(tx_c)) begin // [R5] [R6]
          state_next.tx_state = STS_IDLE;
        end else if (sts_at_end(tx_c, state_reg.tx_count)) begin // [R4]
          state_next.tx_state = STS_DONE;
        end
      end
      default: state_next.tx_state = STS_IDLE;
    endcase

    // rx engine, counts only words accepted by the buffer
    case (state_reg.rx_state)
      STS_IDLE: begin
        if (sts_armed(rx_c)) begin // [R5] [R6]
          state_next.rx_state     = STS_RUN;
          state_next.rx_count     = 10'h000;
          state_next.rx_signature = `STS_SIG_RESET;
        end
      end
      // the buffer keeps draining while done waits for start or enable to drop
      STS_DONE: begin
        if (!sts_armed(rx_c)) begin
          state_next.rx_state = STS_IDLE;
        end
      end
      STS_RUN: begin
        if (!sts_armed(rx_c)) begin // [R5] [R6]
          state_next.rx_state = STS_IDLE;
        end else if (rx_go) begin
          state_next.rx_signature = sts_sig_step(state_reg.rx_signature,
                                                 rx_word_in.i_word);
          state_next.rx_count = state_reg.rx_count + 10'h001;
          if (sts_at_end(rx_c, state_reg.rx_count)) begin // [R4]
            state_next.rx_state = STS_DONE;
          end
        end
      end
      default: state_next.rx_state = STS_IDLE;
    endcase

    // registered rx output stage
    if (rx_out_take) begin
      state_next.rx_out_valid = rx_buf_valid;
      state_next.rx_out_word  = rx_buf_word;
    end

    state_next.tx_running = (state_next.tx_state == STS_RUN);
    state_next.rx_running = (state_next.rx_state == STS_RUN);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg          <= '0;
      state_reg.tx_ctrl  <= `STS_CTRL_RESET;
      state_reg.rx_ctrl  <= `STS_CTRL_RESET;
      state_reg.tx_state <= STS_IDLE;
      state_reg.rx_state <= STS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  //==========================================================
  // outputs
  assign reg_rdata     = state_reg.rdata;
  assign rx_test_valid = state_reg.rx_out_valid;
  assign rx_test_word  = state_reg.rx_out_word;
  assign tx_running    = state_reg.tx_running;
  assign rx_running    = state_reg.rx_running;

endmodule

// file: tb/sts_selftest_chk.sv
`timescale 1ns/10ps
// ==========================================
// port checker
module sts_selftest_chk
  import sts_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  input  wire logic [7:0]   reg_rdata,
  input  wire logic         rx_test_valid,
  input  wire logic         rx_test_ready,
  input  sts_pair_type      rx_test_word,
  input  wire logic         tx_running,
  input  wire logic         rx_running
);
  logic [4:0] tx_ctrl_reg;
  logic [4:0] rx_ctrl_reg;
  logic [9:0] tx_cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadow of the control writes, since the checker cannot see inside
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_ctrl_reg <= 5'h00;
      rx_ctrl_reg <= 5'h00;
      tx_cnt_reg  <= 10'h000;
    end else begin
      if (reg_write && reg_addr == 8'h50) tx_ctrl_reg <= reg_wdata[4:0];
      if (reg_write && reg_addr == 8'h51) rx_ctrl_reg <= reg_wdata[4:0];
      tx_cnt_reg <= tx_running ? tx_cnt_reg + 10'h001 : 10'h000;
    end
  end
  chk_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property ($past(reg_read) && ($past(reg_addr) < 8'h50 ||
    $past(reg_addr) > 8'h56) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_tx_start_ctrl: assert property ($rose(tx_running) |-> tx_ctrl_reg[1:0] == 2'b11)
    else $error("tx run without enable and start");
  chk_rx_start_ctrl: assert property ($rose(rx_running) |-> rx_ctrl_reg[1:0] == 2'b11)
    else $error("rx run without enable and start");
  chk_tx_abort_idle: assert property ($fell(tx_ctrl_reg[1]) |-> ##[0:3] !tx_running)
    else $error("tx run not aborted");
  chk_tx_run_len: assert property ($fell(tx_running) && tx_ctrl_reg[2:0] == 3'b011
    |-> tx_cnt_reg == 10'h200)
    else $error("tx finite run length wrong");
  chk_tx_forever: assert property (tx_running && tx_ctrl_reg[2:0] == 3'b111
    && !reg_write |=> tx_running)
    else $error("endless tx run stopped");
  chk_rx_word_hold: assert property (rx_test_valid && !rx_test_ready
    |=> rx_test_valid && $stable(rx_test_word))
    else $error("stalled rx word lost");
endmodule

bind sts_selftest sts_selftest_chk u_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .rx_test_valid(rx_test_valid), .rx_test_ready(rx_test_ready),
  .rx_test_word(rx_test_word), .tx_running(tx_running), .rx_running(rx_running)
);

// file: tb/sts_bb_model.sv
`timescale 1ns/10ps
// ==========================================
// baseband side: pin words and rx consumer
module sts_bb_model
  import sts_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         slow,
  input  sts_pair_type      pin_word,
  output logic              rx_test_ready,
  output sts_pair_type      tx_pins,
  output sts_pair_type      rx_pins
);
  logic [1:0] phase;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase         <= 2'h0;
      rx_test_ready <= 1'b0;
    end else begin
      phase         <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      // slow consumer stalls one cycle in three
      rx_test_ready <= !slow || (phase != 2'h0);
    end
  end
  assign tx_pins = pin_word;
  assign rx_pins = pin_word;
endmodule

// file: tb/tb_tx_rx_datapath_self_test.sv
`timescale 1ns/10ps
// ==========================================
// bench
module tb_tx_rx_datapath_self_test;
  import sts_pkg::*;
  localparam logic [7:0] MODES [0:2] = '{8'h03, 8'h13, 8'h0b};
  logic         clk, rstn, reg_write, reg_read, slow;
  logic         rx_test_valid, rx_test_ready, tx_running, rx_running;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, d;
  sts_pair_type tx_pins, rx_pins, rx_test_word, pin_word;
  sts_pair_type got_q[$];
  sts_pair_type exp_q[$];
  int           err_total, checked;

  sts_selftest dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_pins(tx_pins),
    .rx_pins(rx_pins), .rx_test_valid(rx_test_valid), .rx_test_ready(rx_test_ready),
    .rx_test_word(rx_test_word), .tx_running(tx_running), .rx_running(rx_running));
  sts_bb_model u_bb (.clk(clk), .rstn(rstn), .slow(slow), .pin_word(pin_word),
    .rx_test_ready(rx_test_ready), .tx_pins(tx_pins), .rx_pins(rx_pins));

  always #4 clk = ~clk;
  always @(posedge clk) if (rx_test_valid && rx_test_ready) got_q.push_back(rx_test_word);

  task automatic final_report();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string w);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic cmpw(input sts_pair_type g, input sts_pair_type e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t rx word got %h exp %h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // n edges until the run flag reaches lvl; bound exhausted ends the run
  task automatic wait_run(input bit rx, input logic lvl, input int bound, output int n);
    n = 0;
    while ((rx ? rx_running : tx_running) !== lvl && n < bound) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= bound) begin
      err_total++;
      $display("[ERR] %0t wait timed out", $time);
      final_report();
    end
  endtask
  // expected word stream of one finite run
  task automatic build_exp(input logic [7:0] c);
    logic [11:0] lf;
    lf = 12'hfff;
    exp_q = {};
    for (int k = 0; k < 512; k++) begin
      if (c[3]) exp_q.push_back(pin_word);
      else if (c[4]) exp_q.push_back(k[0] ? {2{12'h5a5}} : {2{12'ha5a}});
      else exp_q.push_back({lf, ~lf});
      lf = {lf[10:0], lf[11] ^ lf[5] ^ lf[3] ^ lf[0]};
    end
  endtask

  task automatic test_regs();
    for (int a = 8'h50; a < 8'h56; a++) begin
      reg_rd(a[7:0], d);
      cmp8(d, 8'h00, "reset value");
    end
    reg_rd(8'h70, d);
    cmp8(d, 8'h00, "unmapped");
    reg_wr(8'h51, 8'he4);
    reg_rd(8'h51, d);
    cmp8(d, 8'h04, "rx ctrl upper bits");
    reg_wr(8'h50, 8'h01);
    repeat (20) @(posedge clk);
    cmp8({7'h0, tx_running}, 8'h00, "start low idle");
    reg_wr(8'h50, 8'h02);
    repeat (20) @(posedge clk);
    cmp8({7'h0, tx_running}, 8'h00, "enable low idle");
    reg_wr(8'h50, 8'h00);
    reg_wr(8'h51, 8'h00);
    $display("test regs done");
  endtask
  task automatic test_tx_modes();
    int n;
    logic [31:0] es;
    for (int m = 0; m < 3; m++) begin
      build_exp(MODES[m]);
      es = 32'h0;
      foreach (exp_q[k]) begin
        es[31:16] = {es[30:16], es[31] ^ es[30] ^ es[28] ^ es[19]} ^ {4'h0, exp_q[k].i_word};
        es[15:0] = {es[14:0], es[15] ^ es[14] ^ es[12] ^ es[3]} ^ {4'h0, exp_q[k].q_word};
      end
      reg_wr(8'h50, MODES[m]);
      wait_run(1'b0, 1'b1, 20, n);
      wait_run(1'b0, 1'b0, 600, n);
      cmp8(n[7:0], 8'h00, "tx run length low");
      cmp8(n[15:8], 8'h02, "tx run length high");
      reg_wr(8'h52, 8'hff);
      for (int a = 0; a < 4; a++) begin
        reg_rd(8'h52 + a[7:0], d);
        cmp8(d, es[31 - 8 * a -: 8], "tx signature");
      end
      reg_wr(8'h50, 8'h00);
    end
    $display("test tx modes done");
  endtask
  task automatic test_tx_forever();
    int n;
    reg_wr(8'h50, 8'h07);
    wait_run(1'b0, 1'b1, 20, n);
    repeat (600) @(posedge clk);
    #1;
    cmp8({7'h0, tx_running}, 8'h01, "endless run");
    reg_rd(8'h56, d);
    cmp8(d, 8'h01, "status running");
    reg_wr(8'h50, 8'h05);
    repeat (4) @(posedge clk);
    #1;
    cmp8({7'h0, tx_running}, 8'h00, "abort by start");
    reg_wr(8'h50, 8'h00);
    $display("test tx forever done");
  endtask
  task automatic test_rx_modes();
    int n;
    for (int m = 0; m < 3; m++) begin
      build_exp(MODES[m]);
      slow <= (m != 0);
      got_q = {};
      reg_wr(8'h51, MODES[m]);
      wait_run(1'b1, 1'b1, 20, n);
      n = 0;
      while (got_q.size() < 512 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 3000) begin
        err_total++;
        $display("[ERR] %0t rx words timed out", $time);
        final_report();
      end
      repeat (20) @(posedge clk);
      cmp8(got_q.size() == 512, 8'h01, "rx word count");
      foreach (exp_q[k]) cmpw(got_q[k], exp_q[k]);
      reg_wr(8'h51, 8'h00);
    end
    $display("test rx modes done");
  endtask

  initial begin
    clk       = 1'b0;
    rstn      = 1'b0;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    slow      = 1'b0;
    pin_word  = {12'h3c7, 12'h9e1};
    err_total = 0;
    checked   = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    test_regs();
    test_tx_modes();
    test_tx_forever();
    test_rx_modes();
    final_report();
  end
endmodule
